// ---- core/area_decoder.sv ----
// Address compare, area priority and setting selection for one bus address
`timescale 1ns/10ps
module area_decoder
    import csw_pkg::*;
(
    // Address under decode
    input wire logic [ADDR_W-1:0] addr,
    // Programmed areas
    input wire area_cfg_t [NUM_AREAS-1:0] area_ctrl,
    input wire area_cfg_t default_ctrl,
    input wire logic [NUM_AREAS-1:0][7:0] start,
    input wire logic [NUM_AREAS-1:0][15:0] mask,
    // Result
    output logic [NUM_AREAS-1:0] hit,
    output area_cfg_t sel
);

    logic [NUM_AREAS-1:0] match;

    ////////////////////////////////////////////////////////////////////////////////
    // Per-area compare on A23..A8, masked bits left out
    for (genvar i = 0; i < NUM_AREAS; i++)
    begin : g_area
        logic [15:0] diff;
        logic masked_hit;
        logic fixed_hit;
        assign diff = {start[i], 8'h00} ^ addr[ADDR_W-1:8]; // [RQ22]
        assign masked_hit = ((diff & ~mask[i]) == 16'h0000); // [RQ23]
        assign fixed_hit = ((addr >= A2_LO_START) && (addr <= A2_LO_END)) ||
                           (addr >= A2_HI_START);
        if (i == 2)
        begin : g_wide
            // Wide range ignores start and mask until mode is set
            assign match[i] = area_ctrl[i].master_enable &&
                              (area_ctrl[i].decode_mode ? masked_hit : fixed_hit); // [RQ14] [RQ15]
        end
        else
        begin : g_plain
            assign match[i] = area_ctrl[i].master_enable && masked_hit; // [RQ1] [RQ21]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Lowest-numbered match wins, otherwise default settings
    always_comb
    begin
        hit = '0;
        sel = default_ctrl; // [RQ13]
        for (int i = NUM_AREAS - 1; i >= 0; i--)
        begin
            if (match[i])
            begin
                hit = '0;
                hit[i] = 1'b1; // [RQ24]
                sel = area_ctrl[i];
            end
        end
    end

endmodule

// ---- core/chip_select_wait_control.sv ----
// Chip select / wait controller with dynamic bus sizing and an Avalon-MM register slave
//
// Functional notes
// [RQ1] Bit 7 master enable gates each area
// [RQ2] Reset enables only area 2
// [RQ3] Bit 3 picks 16-bit or 8-bit bus
// [RQ4] Split wide operands, low part first, ascending
// [RQ5] Ignore unused lanes on reads
// [RQ6] Float unused lanes, keep their strobe high
// [RQ7] Code 000 gives exactly two waits
// [RQ8] Code 001 gives exactly one wait
// [RQ9] Code 010: one wait, then wait pin
// [RQ10] Code 011 gives no waits
// [RQ11] Software never writes reserved wait codes
// [RQ12] Reset sets wait fields to two waits
// [RQ13] Unmatched addresses use default-area settings
// [RQ14] Area 2 fixed wide range when mode 0
// [RQ15] Area 2 uses start/mask when mode 1
// [RQ16] Reset clears area 2 mode bit
// [RQ17] Software programs start, mask, then control
// [RQ18] Pin shows select only when function bit set
// [RQ19] Internal accesses assert no chip select
// [RQ20] Software keeps waveform field at 00
// [RQ21] Matched area drives select and settings
// [RQ22] Start byte sits on A23..A16
// [RQ23] Compare only address bits with mask 0
// [RQ24] Lowest-numbered matching area wins
// [RQ25] Control registers are write-only to software
// [RQ26] Select low through whole cycle and waits
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/10ps
module chip_select_wait_control
    import csw_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // Avalon-MM register slave
    input wire logic [AV_ADDR_W-1:0] AV_ADDRESS,
    input wire logic AV_READ,
    input wire logic AV_WRITE,
    input wire logic [31:0] AV_WRITEDATA,
    input wire logic [3:0] AV_BYTEENABLE,
    output logic [31:0] AV_READDATA,
    output logic AV_WAITREQUEST,
    // CPU-side request and answer
    input wire mem_req_t REQ,
    output logic REQ_READY,
    output logic RSP_DONE,
    output logic [OP_W-1:0] RSP_RDATA,
    // External memory bus
    output logic [ADDR_W-1:0] MEM_ADDR,
    output logic [BUS_W-1:0] MEM_D_OUT,
    output logic [1:0] MEM_D_OE,
    input wire logic [BUS_W-1:0] MEM_D_IN,
    output logic MEM_RD_N,
    output logic MEM_WR_LO_N,
    output logic MEM_WR_HI_N,
    input wire logic MEM_WAIT_N,
    // Chip select pins shared with port 6
    output logic [NUM_AREAS-1:0] CS_PIN_N
);

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    ////////////////////////////////////////////////////////////////////////////////
    // Register file
    area_cfg_t [NUM_AREAS-1:0] area_ctrl_ff;
    area_cfg_t default_ctrl_ff;
    logic [NUM_AREAS-1:0][7:0] start_ff;
    logic [NUM_AREAS-1:0][15:0] mask_ff;
    logic [NUM_AREAS-1:0] port_func_ff;
    logic [NUM_AREAS-1:0] port_data_ff;
    logic av_wait_ff;
    logic [31:0] av_rdata_ff;
    logic [7:0] idx;
    logic aligned;
    logic wr_take;
    logic [31:0] nxt_rdata_bus;

    assign idx = AV_ADDRESS[AV_ADDR_W-1:2];
    assign aligned = (AV_ADDRESS[1:0] == 2'h0);
    // Write lands only at the edge where waitrequest is seen low
    assign wr_take = AV_WRITE && !av_wait_ff && aligned;

    // Bus engine state, declared early for the status read
    bus_state_t state_ff;
    logic [2:0] last_area_ff;

    // Control registers, only the low byte lane carries them
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            for (int i = 0; i < NUM_AREAS; i++)
                area_ctrl_ff[i] <= (i == 2) ? AREA2_CTRL_RST : AREA_CTRL_RST; // [RQ2] [RQ12] [RQ16]
            default_ctrl_ff <= DEFAULT_CTRL_RST; // [RQ12]
        end
        else if (wr_take && AV_BYTEENABLE[0])
        begin
            for (int i = 0; i < NUM_AREAS; i++)
                if (idx == IDX_AREA0 + 8'(i))
                    area_ctrl_ff[i] <= AV_WRITEDATA[7:0]; // [RQ1] [RQ3]
            // Default area has only width and wait bits
            if (idx == IDX_DEFAULT)
                default_ctrl_ff <= {4'h0, AV_WRITEDATA[3:0]}; // [RQ13]
        end
    end

    // Start, mask and port function registers
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            start_ff <= {NUM_AREAS{START_RST}};
            mask_ff <= {NUM_AREAS{MASK_RST}};
            port_func_ff <= PORT_RST;
            port_data_ff <= PORT_DATA_RST;
        end
        else if (wr_take)
        begin
            for (int i = 0; i < NUM_AREAS; i++)
            begin
                if (idx == IDX_START0 + 8'(i) && AV_BYTEENABLE[0])
                    start_ff[i] <= AV_WRITEDATA[7:0];
                if (idx == IDX_MASK0 + 8'(i) && AV_BYTEENABLE[0])
                    mask_ff[i][7:0] <= AV_WRITEDATA[7:0];
                if (idx == IDX_MASK0 + 8'(i) && AV_BYTEENABLE[1])
                    mask_ff[i][15:8] <= AV_WRITEDATA[15:8];
            end
            if (idx == IDX_PORT_FUNC && AV_BYTEENABLE[0])
                port_func_ff <= AV_WRITEDATA[NUM_AREAS-1:0]; // [RQ18]
            if (idx == IDX_PORT_DATA && AV_BYTEENABLE[0])
                port_data_ff <= AV_WRITEDATA[NUM_AREAS-1:0];
        end
    end

    // Read mux; control registers are write-only and read zero
    always_comb
    begin
        nxt_rdata_bus = 32'h0000_0000;
        if (aligned)
        begin
            for (int i = 0; i < NUM_AREAS; i++)
            begin
                if (idx == IDX_START0 + 8'(i))
                    nxt_rdata_bus = {24'h00_0000, start_ff[i]};
                if (idx == IDX_MASK0 + 8'(i))
                    nxt_rdata_bus = {16'h0000, mask_ff[i]};
            end
            if (idx == IDX_PORT_FUNC)
                nxt_rdata_bus = {28'h000_0000, port_func_ff};
            if (idx == IDX_PORT_DATA)
                nxt_rdata_bus = {28'h000_0000, port_data_ff};
            if (idx == IDX_STATUS)
                nxt_rdata_bus = {28'h000_0000, (state_ff != ST_IDLE), last_area_ff};
        end
    end

    // One-cycle waitrequest drop per request, then back high
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            av_wait_ff <= 1'b1;
            av_rdata_ff <= 32'h0000_0000;
        end
        else if ((AV_READ || AV_WRITE) && av_wait_ff)
        begin
            av_wait_ff <= 1'b0;
            av_rdata_ff <= AV_READ ? nxt_rdata_bus : 32'h0000_0000;
        end
        else
            av_wait_ff <= 1'b1;
    end

    assign AV_WAITREQUEST = av_wait_ff;
    assign AV_READDATA = av_rdata_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus engine
    logic [NUM_AREAS-1:0] dec_hit;
    area_cfg_t dec_sel;
    logic [ADDR_W-1:0] addr_ff;
    logic op_write_ff;
    logic [OP_W-1:0] wdata_ff;
    logic [OP_W-1:0] rdata_ff;
    logic [1:0] byte_idx_ff;
    logic [2:0] remain_ff;
    logic [1:0] wait_cnt_ff;
    logic ext_wait_ff;
    logic [2:0] nb_ff;
    logic lane_lo_ff;
    logic lane_hi_ff;
    logic ready_ff;
    logic done_ff;
    logic [2:0] nxt_nb;
    logic nxt_lo;
    logic nxt_hi;
    logic [7:0] byte0;
    logic [7:0] byte1;
    logic [1:0] nxt_wait_cnt;
    logic [OP_W-1:0] nxt_rdata;
    logic take;
    logic acc_end;

    area_decoder u_decoder (
        .addr(addr_ff),
        .area_ctrl(area_ctrl_ff),
        .default_ctrl(default_ctrl_ff),
        .start(start_ff),
        .mask(mask_ff),
        .hit(dec_hit),
        .sel(dec_sel)
    );

    assign take = REQ.valid && ready_ff;
    // Cycle ends once the count runs out and the wait pin, if watched, is high
    assign acc_end = (state_ff == ST_ACCESS) && (wait_cnt_ff == CNT_NONE) &&
                     !(ext_wait_ff && !MEM_WAIT_N); // [RQ9]
    assign byte0 = wdata_ff[{byte_idx_ff, 3'h0} +: LANE_W];
    assign byte1 = wdata_ff[{byte_idx_ff + 2'h1, 3'h0} +: LANE_W];

    // Lane plan of the next access
    always_comb
    begin
        nxt_nb = BYTES_1;
        nxt_lo = 1'b1;
        nxt_hi = 1'b0;
        if (!dec_sel.width_select) // [RQ3]
        begin
            if (addr_ff[0])
            begin
                nxt_lo = 1'b0; // [RQ4]
                nxt_hi = 1'b1;
            end
            else if (remain_ff >= BYTES_2)
            begin
                nxt_hi = 1'b1;
                nxt_nb = BYTES_2;
            end
        end
    end

    // Wait states loaded at the start of each access
    always_comb
    begin
        case (dec_sel.wait_select)
            WAIT_TWO: nxt_wait_cnt = CNT_TWO; // [RQ7]
            WAIT_ONE: nxt_wait_cnt = CNT_ONE; // [RQ8]
            WAIT_EXT: nxt_wait_cnt = CNT_ONE; // [RQ9]
            WAIT_NONE: nxt_wait_cnt = CNT_NONE; // [RQ10]
            // Reserved codes fall back to the slowest safe timing
            default: nxt_wait_cnt = CNT_TWO;
        endcase
    end

    // Read assembly, only the lanes in use reach the operand
    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (lane_lo_ff)
            nxt_rdata[{byte_idx_ff, 3'h0} +: LANE_W] = MEM_D_IN[7:0]; // [RQ5]
        if (lane_hi_ff && lane_lo_ff)
            nxt_rdata[{byte_idx_ff + 2'h1, 3'h0} +: LANE_W] = MEM_D_IN[15:8]; // [RQ5]
        else if (lane_hi_ff)
            nxt_rdata[{byte_idx_ff, 3'h0} +: LANE_W] = MEM_D_IN[15:8]; // [RQ5]
    end

    // Sequencer and operand bookkeeping
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state_ff <= ST_IDLE;
            addr_ff <= '0;
            op_write_ff <= 1'b0;
            wdata_ff <= '0;
            rdata_ff <= '0;
            byte_idx_ff <= 2'h0;
            remain_ff <= 3'h0;
            wait_cnt_ff <= CNT_NONE;
            ext_wait_ff <= 1'b0;
            nb_ff <= BYTES_1;
            lane_lo_ff <= 1'b0;
            lane_hi_ff <= 1'b0;
            ready_ff <= 1'b0;
            done_ff <= 1'b0;
            last_area_ff <= AREA_DEFAULT;
        end
        else
        begin
            done_ff <= 1'b0;
            case (state_ff)
                ST_IDLE:
                begin
                    ready_ff <= !take;
                    if (take && REQ.internal)
                    begin
                        rdata_ff <= '0; // [RQ19]
                        done_ff <= 1'b1;
                    end
                    else if (take)
                    begin
                        state_ff <= ST_DECODE;
                        addr_ff <= REQ.addr;
                        op_write_ff <= REQ.write;
                        wdata_ff <= REQ.wdata;
                        rdata_ff <= '0;
                        byte_idx_ff <= 2'h0;
                        remain_ff <= (REQ.size == SIZE_BYTE) ? BYTES_1 :
                                     (REQ.size == SIZE_HALF) ? BYTES_2 : BYTES_4;
                    end
                end
                ST_DECODE:
                begin
                    state_ff <= ST_ACCESS;
                    wait_cnt_ff <= nxt_wait_cnt;
                    ext_wait_ff <= (dec_sel.wait_select == WAIT_EXT);
                    nb_ff <= nxt_nb;
                    lane_lo_ff <= nxt_lo;
                    lane_hi_ff <= nxt_hi;
                    last_area_ff <= AREA_DEFAULT;
                    for (int i = NUM_AREAS - 1; i >= 0; i--)
                        if (dec_hit[i])
                            last_area_ff <= 3'(i);
                end
                ST_ACCESS:
                begin
                    if (wait_cnt_ff != CNT_NONE)
                        wait_cnt_ff <= wait_cnt_ff - CNT_ONE;
                    else if (acc_end)
                    begin
                        rdata_ff <= nxt_rdata;
                        // Ascending addresses, least significant part first
                        addr_ff <= addr_ff + {21'h00_0000, nb_ff}; // [RQ4]
                        byte_idx_ff <= byte_idx_ff + nb_ff[1:0];
                        remain_ff <= remain_ff - nb_ff;
                        lane_lo_ff <= 1'b0;
                        lane_hi_ff <= 1'b0;
                        if (remain_ff == nb_ff)
                        begin
                            state_ff <= ST_IDLE;
                            done_ff <= 1'b1;
                            ready_ff <= 1'b1;
                        end
                        else
                            state_ff <= ST_DECODE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // External pins, set at decode and released at the end of each access
    logic [NUM_AREAS-1:0] cs_n_ff;
    logic [BUS_W-1:0] d_out_ff;
    logic [1:0] d_oe_ff;
    logic rd_n_ff;
    logic wr_lo_n_ff;
    logic wr_hi_n_ff;
    logic [NUM_AREAS-1:0] nxt_cs_n;

    always_comb
    begin
        nxt_cs_n = cs_n_ff;
        if (state_ff == ST_DECODE)
            nxt_cs_n = ~dec_hit; // [RQ21] [RQ26]
        else if (acc_end)
            nxt_cs_n = {NUM_AREAS{1'b1}};
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            cs_n_ff <= {NUM_AREAS{1'b1}};
            d_out_ff <= '0;
            d_oe_ff <= 2'h0;
            rd_n_ff <= 1'b1;
            wr_lo_n_ff <= 1'b1;
            wr_hi_n_ff <= 1'b1;
        end
        else
        begin
            cs_n_ff <= nxt_cs_n;
            if (state_ff == ST_DECODE)
            begin
                // Odd byte on the high lane, otherwise the low lane first
                d_out_ff <= nxt_hi && !nxt_lo ? {byte0, 8'h00} : {byte1, byte0}; // [RQ4]
                d_oe_ff <= op_write_ff ? {nxt_hi, nxt_lo} : 2'h0; // [RQ6]
                rd_n_ff <= op_write_ff;
                wr_lo_n_ff <= !(op_write_ff && nxt_lo); // [RQ6]
                wr_hi_n_ff <= !(op_write_ff && nxt_hi); // [RQ6]
            end
            else if (acc_end)
            begin
                d_oe_ff <= 2'h0;
                rd_n_ff <= 1'b1;
                wr_lo_n_ff <= 1'b1;
                wr_hi_n_ff <= 1'b1;
            end
        end
    end

    // Port mux per pin; select reaches the pin only with its function bit
    for (genvar i = 0; i < NUM_AREAS; i++)
    begin : g_pin
        logic pin_ff;
        always_ff @(posedge CLK or negedge ARST_N)
        begin
            if (!ARST_N)
                pin_ff <= 1'b1;
            else
                pin_ff <= port_func_ff[i] ? nxt_cs_n[i] : port_data_ff[i]; // [RQ18]
        end
        assign CS_PIN_N[i] = pin_ff;
    end

    assign REQ_READY = ready_ff;
    assign RSP_DONE = done_ff;
    assign RSP_RDATA = rdata_ff;
    assign MEM_ADDR = addr_ff;
    assign MEM_D_OUT = d_out_ff;
    assign MEM_D_OE = d_oe_ff;
    assign MEM_RD_N = rd_n_ff;
    assign MEM_WR_LO_N = wr_lo_n_ff;
    assign MEM_WR_HI_N = wr_hi_n_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    logic strobe_on;
    assign strobe_on = !rd_n_ff || !wr_lo_n_ff || !wr_hi_n_ff;

    sequence s_start_wait(logic [2:0] code);
        (state_ff == ST_DECODE) && (dec_sel.wait_select == code);
    endsequence

    a_two_wait_len: assert property (s_start_wait(WAIT_TWO) |=> strobe_on[*3] ##1 !strobe_on) // [RQ7]
        else $error("two-wait cycle length wrong");
    a_one_wait_len: assert property (s_start_wait(WAIT_ONE) |=> strobe_on[*2] ##1 !strobe_on) // [RQ8]
        else $error("one-wait cycle length wrong");
    a_zero_wait_len: assert property (s_start_wait(WAIT_NONE) |=> strobe_on ##1 !strobe_on) // [RQ10]
        else $error("zero-wait cycle length wrong");
    a_ext_wait_min: assert property (s_start_wait(WAIT_EXT) |=> strobe_on[*2]) // [RQ9]
        else $error("extended wait cycle too short");
    a_ext_wait_hold: assert property ((state_ff == ST_ACCESS) && ext_wait_ff && // [RQ9]
        (wait_cnt_ff == CNT_NONE) && !MEM_WAIT_N |=> strobe_on)
        else $error("cycle ended while wait pin low");
    a_cs_whole_cycle: assert property (strobe_on && !$stable(cs_n_ff) |-> $past(state_ff) == ST_DECODE) // [RQ26]
        else $error("select changed inside a cycle");
    a_cs_enabled: assert property ((state_ff == ST_ACCESS) && !cs_n_ff[0] |-> area_ctrl_ff[0].master_enable) // [RQ1]
        else $error("select for disabled area");
    a_lane_float: assert property (!op_write_ff && strobe_on |-> (d_oe_ff == 2'h0)) // [RQ6]
        else $error("lanes driven during read");
    a_narrow_lane: assert property ((state_ff == ST_DECODE) && dec_sel.width_select |=> !d_oe_ff[1] && wr_hi_n_ff) // [RQ3] [RQ4]
        else $error("high lane used on 8-bit area");
    a_internal_quiet: assert property (take && REQ.internal |=> (cs_n_ff == 4'hF) && done_ff) // [RQ19]
        else $error("internal access touched select pins");
    a_one_hot_cs: assert property ($onehot0(~cs_n_ff)) // [RQ24]
        else $error("more than one select low");

endmodule

// ---- core/csw_pkg.sv ----
// Shared types, register map and timing constants for the chip select / wait controller
package csw_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int NUM_AREAS = 4;
    localparam int ADDR_W = 24;
    localparam int AV_ADDR_W = 10;
    localparam int OP_W = 32;
    localparam int LANE_W = 8;
    localparam int BUS_W = 16;

    ////////////////////////////////////////////////////////////////////////////////
    // Area control byte, bit 7 down to bit 0
    typedef struct packed {
        logic       master_enable;
        logic       decode_mode;
        logic [1:0] select_waveform;
        logic       width_select;
        logic [2:0] wait_select;
    } area_cfg_t;

    // Request from the CPU side
    typedef struct packed {
        logic              valid;
        logic              write;
        logic              internal;
        logic [1:0]        size;
        logic [ADDR_W-1:0] addr;
        logic [OP_W-1:0]   wdata;
    } mem_req_t;

    typedef enum logic [1:0] {ST_IDLE, ST_DECODE, ST_ACCESS} bus_state_t;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] AREA_CTRL_RST = 8'h00;
    localparam logic [7:0] AREA2_CTRL_RST = 8'h80;
    localparam logic [7:0] DEFAULT_CTRL_RST = 8'h00;
    localparam logic [7:0] START_RST = 8'hFF;
    localparam logic [15:0] MASK_RST = 16'hFFFF;
    localparam logic [3:0] PORT_RST = 4'h0;
    localparam logic [3:0] PORT_DATA_RST = 4'hF;

    // Wait field encodings and the wait states each inserts
    localparam logic [2:0] WAIT_TWO = 3'h0;
    localparam logic [2:0] WAIT_ONE = 3'h1;
    localparam logic [2:0] WAIT_EXT = 3'h2;
    localparam logic [2:0] WAIT_NONE = 3'h3;
    localparam logic [1:0] CNT_TWO = 2'h2;
    localparam logic [1:0] CNT_ONE = 2'h1;
    localparam logic [1:0] CNT_NONE = 2'h0;

    // Operand size encodings and byte counts
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [2:0] BYTES_1 = 3'h1;
    localparam logic [2:0] BYTES_2 = 3'h2;
    localparam logic [2:0] BYTES_4 = 3'h4;

    // Fixed wide range of area 2
    localparam logic [ADDR_W-1:0] A2_LO_START = 24'h00_1800;
    localparam logic [ADDR_W-1:0] A2_LO_END = 24'h01_F7FF;
    localparam logic [ADDR_W-1:0] A2_HI_START = 24'h02_0000;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices, byte address is four times the index
    localparam logic [7:0] IDX_AREA0 = 8'hC0;
    localparam logic [7:0] IDX_AREA1 = 8'hC1;
    localparam logic [7:0] IDX_AREA2 = 8'hC2;
    localparam logic [7:0] IDX_AREA3 = 8'hC3;
    localparam logic [7:0] IDX_DEFAULT = 8'hC7;
    localparam logic [7:0] IDX_START0 = 8'hD0;
    localparam logic [7:0] IDX_MASK0 = 8'hD4;
    localparam logic [7:0] IDX_PORT_FUNC = 8'hD8;
    localparam logic [7:0] IDX_PORT_DATA = 8'hD9;
    localparam logic [7:0] IDX_STATUS = 8'hDA;

    // Area code reported when no programmable area matched
    localparam logic [2:0] AREA_DEFAULT = 3'h4;

endpackage

// ---- testbench/ext_memory.sv ----
// Behavioural external byte-addressed memory with a wait pin
`timescale 1ns/10ps
module ext_memory
(
    // Bus from the controller
    input wire logic clk,
    input wire logic [23:0] addr,
    input wire logic [15:0] d_out,
    input wire logic rd_n,
    input wire logic wr_lo_n,
    input wire logic wr_hi_n,
    input wire logic [3:0] stall,
    // Answer to the controller
    output logic [15:0] d_in,
    output logic wait_n
);
    logic [7:0] mem [0:511];
    logic [15:0] last = 16'h0000;
    logic [3:0] cnt = 4'h0;
    // Released bus shows the inverse, so stale data never looks right
    assign d_in = !rd_n ? {mem[addr[8:0] | 9'h001], mem[addr[8:0]]} : ~last;
    // Held low for stall cycles from the start of each access
    assign wait_n = (cnt == 4'h0);
    always @(posedge clk)
    begin
        if (!rd_n) last <= d_in;
        if (!wr_lo_n) mem[addr[8:0]] <= d_out[7:0];
        if (!wr_hi_n) mem[addr[8:0] | 9'h001] <= d_out[15:8];
        cnt <= (rd_n && wr_lo_n && wr_hi_n) ? stall : (cnt != 4'h0) ? cnt - 4'h1 : cnt;
    end
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the chip select / wait controller
`timescale 1ns/10ps
module testbench;
    import csw_pkg::*;
    logic clk = 0, arst_n = 0, rd = 0, wr = 0, rdy, done, rd_n, wl_n, wh_n, wt_n, wq;
    logic [9:0] adr = 10'h000;
    logic [31:0] wd = 32'h0000_0000, rdata, avrd, stb, csc;
    logic [3:0] stall = 4'h0, csv, cs_n;
    logic [1:0] oe, oev;
    logic [15:0] dout, din;
    logic [23:0] ma;
    mem_req_t req = '0;
    int bad_count = 0, cmp_count = 0, cyc = 0;
    int wexp [4] = '{3, 2, 2, 1};
    chip_select_wait_control chip_select_wait_control_inst (.CLK(clk), .ARST_N(arst_n),
        .AV_ADDRESS(adr), .AV_READ(rd), .AV_WRITE(wr), .AV_WRITEDATA(wd),
        .AV_BYTEENABLE(4'hF), .AV_READDATA(avrd), .AV_WAITREQUEST(wq), .REQ(req),
        .REQ_READY(rdy), .RSP_DONE(done), .RSP_RDATA(rdata), .MEM_ADDR(ma),
        .MEM_D_OUT(dout), .MEM_D_OE(oe), .MEM_D_IN(din), .MEM_RD_N(rd_n),
        .MEM_WR_LO_N(wl_n), .MEM_WR_HI_N(wh_n), .MEM_WAIT_N(wt_n), .CS_PIN_N(cs_n));
    ext_memory ext_memory_inst (.clk(clk), .addr(ma), .d_out(dout), .rd_n(rd_n),
        .wr_lo_n(wl_n), .wr_hi_n(wh_n), .stall(stall), .d_in(din), .wait_n(wt_n));
    ////////////////////////////////////////////////////////////////////////////////
    initial forever #4 clk = ~clk;
    task automatic chk(input string n, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e)
        begin
            bad_count++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    // Register access, held until waitrequest is seen low
    task automatic av(input logic r, input logic [9:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        rd <= r;
        wr <= !r;
        @(posedge clk);
        while (wq) @(posedge clk);
        if (r) chk("readdata", avrd, d);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // CPU request; counts strobe and select cycles up to the done pulse
    task automatic cpu(input logic w, i, input logic [1:0] z, input logic [23:0] a,
                       input logic [31:0] d);
        @(negedge clk);
        while (!rdy) @(negedge clk);
        @(posedge clk);
        req <= '{1'b1, w, i, z, a, d};
        @(posedge clk);
        req.valid <= 1'b0;
        stb = 0;
        csc = 0;
        oev = 0;
        csv = 4'hF;
        do
        begin
            @(negedge clk);
            if (!(rd_n && wl_n && wh_n)) stb++;
            if (cs_n != 4'hF) csc++;
            if (cs_n != 4'hF) csv = cs_n;
            oev |= oe;
        end
        while (!done);
    endtask
    task automatic finish_test;
        if (bad_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles the sequence needs
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            bad_count++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        av(1'b0, 10'h360, 32'h0000_000F);
        av(1'b1, 10'h300, 32'h0000_0000);
        av(1'b1, 10'h3F0, 32'h0000_0000);
        // Reset settings: area 2 wide range, 16 bits, two waits
        cpu(1'b1, 1'b0, SIZE_HALF, 24'h00_2000, 32'h0000_A55A);
        chk("strobes", stb, 3);
        chk("select cycles", csc, 3);
        chk("select", csv, 4'hB);
        // Each wait code on a halfword read
        for (int k = 0; k < 4; k++)
        begin
            av(1'b0, 10'h308, 32'h0000_0080 | k);
            cpu(1'b0, 1'b0, SIZE_HALF, 24'h00_2000, 0);
            chk("wait strobes", stb, wexp[k]);
            chk("half read", rdata[15:0], 16'hA55A);
        end
        stall <= 4'h6;
        av(1'b0, 10'h308, 32'h0000_0082);
        cpu(1'b0, 1'b0, SIZE_HALF, 24'h00_2000, 0);
        chk("extended", stb, 7);
        stall <= 4'h0;
        av(1'b0, 10'h308, 32'h0000_0083);
        // Odd byte on a 16-bit area uses only the high lane
        cpu(1'b1, 1'b0, SIZE_BYTE, 24'h00_2001, 32'h0000_00EE);
        chk("lanes", oev, 2'b10);
        cpu(1'b0, 1'b0, SIZE_HALF, 24'h00_2000, 0);
        chk("merged", rdata[15:0], 16'hEE5A);
        // Area 0 over part of area 2, lowest number wins
        av(1'b0, 10'h340, 32'h0000_0001);
        av(1'b0, 10'h350, 32'h0000_00FF);
        av(1'b0, 10'h300, 32'h0000_0083);
        cpu(1'b0, 1'b0, SIZE_BYTE, 24'h01_8000, 0);
        chk("area0", csv, 4'hE);
        av(1'b0, 10'h300, 32'h0000_0003);
        cpu(1'b0, 1'b0, SIZE_BYTE, 24'h01_8000, 0);
        chk("area0 off", csv, 4'hB);
        // Area 2 decoded from start and mask
        av(1'b0, 10'h348, 32'h0000_0001);
        av(1'b0, 10'h358, 32'h0000_00FF);
        av(1'b0, 10'h308, 32'h0000_00C3);
        cpu(1'b0, 1'b0, SIZE_BYTE, 24'h01_F810, 0);
        chk("area2 mode", csv, 4'hB);
        // Default area: 8 bits, no waits, word split into four bytes
        av(1'b0, 10'h31C, 32'h0000_000B);
        cpu(1'b1, 1'b0, 2'h2, 24'h00_0101, 32'h1234_5678);
        chk("byte strobes", stb, 4);
        chk("no select", csc, 0);
        cpu(1'b0, 1'b0, 2'h2, 24'h00_0101, 0);
        chk("word read", rdata, 32'h1234_5678);
        cpu(1'b0, 1'b1, SIZE_HALF, 24'h05_0010, 0);
        chk("internal", csc + stb + rdata, 0);
        finish_test();
    end
endmodule
